// ===== inc/ffc_regs.svh
`ifndef FFC_REGS_SVH
`define FFC_REGS_SVH

// Register offsets
`define FFC_OFS_SUPPLY_MON 8'h80
`define FFC_OFS_TORCH 8'ha0
`define FFC_OFS_FLASH 8'hb0
`define FFC_OFS_DURATION 8'hc0
`define FFC_OFS_STATUS 8'hd0
`define FFC_OFS_CFG1 8'he0
`define FFC_OFS_CFG2 8'hf0

// Reset values
`define FFC_RST_TORCH 8'h50
`define FFC_RST_FLASH 8'h68
`define FFC_RST_DURATION 8'h4f
`define FFC_RST_STATUS 8'h40
`define FFC_RST_CFG1 8'h42
`define FFC_RST_CFG2 8'hf0
`define FFC_RST_SUPPLY_MON 8'hf0

// Status bit positions
`define FFC_ST_EXPIRY 0
`define FFC_ST_OVERTEMP 1
`define FFC_ST_LED_FAIL 2
`define FFC_ST_TX1 3
`define FFC_ST_TX2 4
`define FFC_ST_THERM 5
`define FFC_ST_SUPPLY 6

// First configuration bits
`define FFC_C1_LL_DIS 0
`define FFC_C1_OUT_LVL 1
`define FFC_C1_STROBE_EDGE 2
`define FFC_C1_THERM_MODE 3
`define FFC_C1_TX2_MODE 5
`define FFC_C1_TX2_POL 6
`define FFC_C1_TX1_TORCH 7

// Second configuration bits
`define FFC_C2_TX2_OFF 0
`define FFC_C2_THERM_OFF 1
`define FFC_C2_SUPPLY_OFF 3

// Supply monitor bits
`define FFC_SM_EN 0

// Timing, times in ns, counts derived from the clock rate
`define FFC_CLK_MHZ 25
`define FFC_RAMP_STEP_NS 16000
`define FFC_SHORT_QUAL_NS 250000
`define FFC_OPEN_QUAL_NS 2000
`define FFC_TIMEOUT_STEP_NS 32000000
`define FFC_RAMP_STEP_CYC ((`FFC_RAMP_STEP_NS * `FFC_CLK_MHZ + 999) / 1000)
`define FFC_SHORT_QUAL_CYC ((`FFC_SHORT_QUAL_NS * `FFC_CLK_MHZ + 999) / 1000)
`define FFC_OPEN_QUAL_CYC ((`FFC_OPEN_QUAL_NS * `FFC_CLK_MHZ + 999) / 1000)
`define FFC_TIMEOUT_STEP_CYC ((`FFC_TIMEOUT_STEP_NS * `FFC_CLK_MHZ) / 1000)

`endif

// ===== inc/ffc_pkg.sv
package ffc_pkg;
	typedef logic [7:0] ffc_byte_t;
	// Gray coded along idle, ramp, hold, done
	typedef enum logic [1:0] {
		FFC_IDLE = 2'b00,
		FFC_RAMP = 2'b01,
		FFC_HOLD = 2'b11,
		FFC_DONE = 2'b10
	} ffc_flash_st_t;
endpackage

// ===== hw/ffc_qual.sv
`timescale 1ns/1ns
// Persistence qualifier: output rises once the sense level has held for LIMIT cycles
module ffc_qual #(
	parameter int LIMIT = 50
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic sense,
	output logic qualified
);
	import ffc_pkg::*;
	localparam int CW = $clog2(LIMIT + 1);
	logic [CW-1:0] cnt_r;

	// Count while the condition persists, restart on any dropout
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= '0;
		end else if (clear || !sense) begin
			cnt_r <= '0;
		end else if (cnt_r != CW'(LIMIT - 1)) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// Registered so a glitch shorter than LIMIT never reaches the flag
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			qualified <= 1'b0;
		end else begin
			qualified <= sense && !clear && (cnt_r == CW'(LIMIT - 1));
		end
	end

	property p_qual_hold;
		@(posedge mclk) disable iff (!reset_n)
		$rose(qualified) |-> $past(sense) && ($past(cnt_r) == CW'(LIMIT - 1));
	endproperty
	a_qual_hold: assert property (p_qual_hold) else $error("qualifier fired early");
endmodule

// ===== hw/ffc_top.sv
`timescale 1ns/1ns
`include "ffc_regs.svh"
module ffc_top #(
	parameter int SHORT_QUAL_CYC = `FFC_SHORT_QUAL_CYC,
	parameter int TIMEOUT_STEP_CYC = `FFC_TIMEOUT_STEP_CYC
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic hardware_enable_pin,
	input wire logic [7:0] reg_addr,
	input wire ffc_pkg::ffc_byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output ffc_pkg::ffc_byte_t reg_rdata,
	input wire logic strobe_pin,
	input wire logic first_transmit_pin,
	input wire logic second_transmit_pin,
	input wire logic overtemp_in,
	input wire logic output_overvoltage,
	input wire logic led_short_in,
	input wire logic thermistor_trip,
	input wire logic supply_undervoltage,
	input wire logic supply_recovered,
	output logic boost_enable,
	output logic led_flash_on,
	output logic led_torch_on,
	output logic [3:0] led_flash_level,
	output logic [2:0] led_torch_level,
	output logic indicator_on,
	output logic [1:0] indicator_level,
	output logic supply_monitor_enable,
	output logic [1:0] uv_threshold_sel,
	output logic output_level_select,
	output logic voltage_mode_active,
	output logic light_load_enable
);
	import ffc_pkg::*;
	localparam int RAMP_CYC = `FFC_RAMP_STEP_CYC;
	localparam int OPEN_CYC = `FFC_OPEN_QUAL_CYC;

	ffc_byte_t torch_r, flash_r, duration_r, status_r, cfg1_r, cfg2_r, supmon_r;
	ffc_byte_t status_nxt, set_v, clr_v;
	logic [2:0] mode_r;
	ffc_flash_st_t st_r, st_nxt;
	logic [8:0] ramp_cyc_r;
	logic [3:0] level_r;
	logic [19:0] to_cyc_r;
	logic [4:0] to_steps_r;
	logic strobe_q, tx1_q, tx2_q, ot_q, strobe_hold_r;
	logic uv_hold_r, uv_read_r, therm_hold_r, tx2_hold_r;
	logic status_rd, wr_mode, flash_req, flash_start, in_flash, ramp_tick, to_expire;
	logic led_active, short_ok, open_ok, tx2_level, tx2_event, tx_force, torch_force, off_force;
	logic sw_torch, vout_mode, hw_off;

	// Disable pin acts as a synchronous clear of every control state
	assign hw_off = !hardware_enable_pin;
	assign status_rd = reg_rd && (reg_addr == `FFC_OFS_STATUS);
	assign wr_mode = reg_wr && (reg_addr == `FFC_OFS_TORCH || reg_addr == `FFC_OFS_FLASH);
	assign led_active = led_flash_on || led_torch_on;
	assign in_flash = (st_r == FFC_RAMP) || (st_r == FFC_HOLD);

	// Register writes; mode bits are one copy shared by both brightness registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			torch_r <= `FFC_RST_TORCH;
			flash_r <= `FFC_RST_FLASH;
			duration_r <= `FFC_RST_DURATION;
			cfg1_r <= `FFC_RST_CFG1;
			cfg2_r <= `FFC_RST_CFG2;
			supmon_r <= `FFC_RST_SUPPLY_MON;
			mode_r <= 3'h0;
		end else if (hw_off) begin
			torch_r <= `FFC_RST_TORCH;
			flash_r <= `FFC_RST_FLASH;
			duration_r <= `FFC_RST_DURATION;
			cfg1_r <= `FFC_RST_CFG1;
			cfg2_r <= `FFC_RST_CFG2;
			supmon_r <= `FFC_RST_SUPPLY_MON;
			mode_r <= 3'h0;
		end else begin
			if (reg_wr) begin
				case (reg_addr)
					`FFC_OFS_TORCH: torch_r <= reg_wdata;
					`FFC_OFS_FLASH: flash_r <= reg_wdata;
					`FFC_OFS_DURATION: duration_r <= reg_wdata;
					`FFC_OFS_CFG1: cfg1_r <= reg_wdata;
					`FFC_OFS_CFG2: cfg2_r <= reg_wdata;
					`FFC_OFS_SUPPLY_MON: supmon_r <= reg_wdata;
					default: ;
				endcase
			end
			// Expiry drops the mode bits even beside an unrelated write, else the flash could never restart
			if (wr_mode) begin
				mode_r <= reg_wdata[2:0];
			end else if (to_expire) begin
				mode_r <= 3'h0;
			end
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`FFC_OFS_TORCH: reg_rdata <= {torch_r[7:3], mode_r};
				`FFC_OFS_FLASH: reg_rdata <= {flash_r[7:3], mode_r};
				`FFC_OFS_DURATION: reg_rdata <= duration_r;
				`FFC_OFS_STATUS: reg_rdata <= status_r;
				`FFC_OFS_CFG1: reg_rdata <= cfg1_r;
				`FFC_OFS_CFG2: reg_rdata <= cfg2_r;
				`FFC_OFS_SUPPLY_MON: reg_rdata <= supmon_r;
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Previous pin levels for edge detection
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			strobe_q <= 1'b0;
			tx1_q <= 1'b0;
			tx2_q <= 1'b0;
			ot_q <= 1'b0;
		end else begin
			strobe_q <= strobe_pin;
			tx1_q <= first_transmit_pin;
			tx2_q <= second_transmit_pin;
			ot_q <= overtemp_in;
		end
	end

	// Edge sensitive strobe is latched until the pulse ends on its own
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			strobe_hold_r <= 1'b0;
		end else if (hw_off || to_expire || st_r == FFC_DONE) begin
			strobe_hold_r <= 1'b0;
		end else if (cfg1_r[`FFC_C1_STROBE_EDGE] && strobe_pin && !strobe_q) begin
			strobe_hold_r <= 1'b1;
		end
	end

	// Level strobe low together with a cleared mode bit withdraws the request
	assign flash_req = (mode_r[1:0] == 2'b11) ||
		(cfg1_r[`FFC_C1_STROBE_EDGE] ? strobe_hold_r : strobe_pin);
	assign flash_start = (st_r == FFC_IDLE) && flash_req && !overtemp_in;
	assign ramp_tick = (ramp_cyc_r == 9'(RAMP_CYC - 1));
	assign to_expire = in_flash && (to_cyc_r == 20'(TIMEOUT_STEP_CYC - 1)) &&
		(to_steps_r == duration_r[4:0]);

	// Flash sequencing
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			FFC_IDLE: if (flash_start) st_nxt = FFC_RAMP;
			FFC_RAMP: begin
				if (!flash_req) st_nxt = FFC_IDLE;
				else if (to_expire) st_nxt = FFC_DONE;
				else if (level_r == flash_r[6:3]) st_nxt = FFC_HOLD;
			end
			FFC_HOLD: begin
				if (!flash_req) st_nxt = FFC_IDLE;
				else if (to_expire) st_nxt = FFC_DONE;
			end
			FFC_DONE: if (!flash_req) st_nxt = FFC_IDLE;
			default: st_nxt = FFC_IDLE;
		endcase
		if (overtemp_in) st_nxt = FFC_IDLE;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= FFC_IDLE;
		end else if (hw_off) begin
			st_r <= FFC_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Current ramp climbs one flash level per step from the lowest code
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ramp_cyc_r <= 9'h000;
			level_r <= 4'h0;
		end else if (hw_off || !in_flash) begin
			ramp_cyc_r <= 9'h000;
			level_r <= 4'h0;
		end else if (ramp_tick) begin
			ramp_cyc_r <= 9'h000;
			if (level_r != flash_r[6:3]) begin
				level_r <= level_r + 1'b1;
			end
		end else begin
			ramp_cyc_r <= ramp_cyc_r + 1'b1;
		end
	end

	// Timeout counts whole steps; field value n gives n plus one steps
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			to_cyc_r <= 20'h00000;
			to_steps_r <= 5'h00;
		end else if (hw_off || !in_flash) begin
			to_cyc_r <= 20'h00000;
			to_steps_r <= 5'h00;
		end else if (to_cyc_r == 20'(TIMEOUT_STEP_CYC - 1)) begin
			to_cyc_r <= 20'h00000;
			to_steps_r <= to_steps_r + 1'b1;
		end else begin
			to_cyc_r <= to_cyc_r + 1'b1;
		end
	end

	// Open and short qualification
	ffc_qual #(.LIMIT(SHORT_QUAL_CYC)) u_short_qual (
		.mclk(mclk),
		.reset_n(reset_n),
		.clear(hw_off),
		.sense(led_short_in && led_active),
		.qualified(short_ok)
	);
	ffc_qual #(.LIMIT(OPEN_CYC)) u_open_qual (
		.mclk(mclk),
		.reset_n(reset_n),
		.clear(hw_off),
		.sense(output_overvoltage && led_active),
		.qualified(open_ok)
	);

	// Transmit pin meanings depend on their configured modes
	assign tx2_level = cfg1_r[`FFC_C1_TX2_POL] ? second_transmit_pin : !second_transmit_pin;
	assign tx2_event = cfg1_r[`FFC_C1_TX2_POL] ? (second_transmit_pin && !tx2_q) :
		(!second_transmit_pin && tx2_q);
	assign tx_force = (!cfg1_r[`FFC_C1_TX1_TORCH] && first_transmit_pin) ||
		(cfg1_r[`FFC_C1_TX2_MODE] && tx2_level && !cfg2_r[`FFC_C2_TX2_OFF]);
	assign torch_force = tx_force || (therm_hold_r && !cfg2_r[`FFC_C2_THERM_OFF]) ||
		(uv_hold_r && !cfg2_r[`FFC_C2_SUPPLY_OFF]);
	assign off_force = tx2_hold_r || (therm_hold_r && cfg2_r[`FFC_C2_THERM_OFF]) ||
		(uv_hold_r && cfg2_r[`FFC_C2_SUPPLY_OFF]);
	assign sw_torch = (mode_r[1:0] == 2'b10);

	// Status event sources
	always_comb begin
		set_v = 8'h00;
		set_v[`FFC_ST_EXPIRY] = to_expire;
		set_v[`FFC_ST_OVERTEMP] = overtemp_in && !ot_q;
		set_v[`FFC_ST_LED_FAIL] = short_ok || open_ok;
		set_v[`FFC_ST_TX1] = !cfg1_r[`FFC_C1_TX1_TORCH] && first_transmit_pin && !tx1_q;
		set_v[`FFC_ST_TX2] = cfg1_r[`FFC_C1_TX2_MODE] && tx2_event;
		set_v[`FFC_ST_THERM] = cfg1_r[`FFC_C1_THERM_MODE] && led_active && thermistor_trip;
		set_v[`FFC_ST_SUPPLY] = supmon_r[`FFC_SM_EN] && supply_undervoltage;
		clr_v = status_rd ? 8'hff : (flash_start ? 8'h01 : 8'h00);
		status_nxt = (status_r & ~clr_v) | set_v;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			status_r <= `FFC_RST_STATUS;
		end else if (hw_off) begin
			status_r <= `FFC_RST_STATUS;
		end else begin
			status_r <= status_nxt;
		end
	end

	// Holds that keep the LEDs reduced until software acknowledges
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			uv_hold_r <= 1'b0;
			uv_read_r <= 1'b0;
		end else if (hw_off) begin
			uv_hold_r <= 1'b0;
			uv_read_r <= 1'b0;
		end else if (supmon_r[`FFC_SM_EN] && supply_undervoltage) begin
			uv_hold_r <= 1'b1;
			uv_read_r <= 1'b0;
		end else if (uv_hold_r) begin
			// Recovery counts only in the cycle of the read or after it; an earlier recovery is missed
			if (status_rd) uv_read_r <= 1'b1;
			if ((status_rd || uv_read_r) && supply_recovered) begin
				uv_hold_r <= 1'b0;
				uv_read_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			therm_hold_r <= 1'b0;
		end else if (hw_off) begin
			therm_hold_r <= 1'b0;
		end else if (set_v[`FFC_ST_THERM]) begin
			therm_hold_r <= 1'b1;
		end else if (status_rd) begin
			therm_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx2_hold_r <= 1'b0;
		end else if (hw_off) begin
			tx2_hold_r <= 1'b0;
		end else if (in_flash && cfg1_r[`FFC_C1_TX2_MODE] && tx2_level && cfg2_r[`FFC_C2_TX2_OFF]) begin
			tx2_hold_r <= 1'b1;
		end else if (status_rd) begin
			tx2_hold_r <= 1'b0;
		end
	end

	// Voltage mode and light load; light load never runs with LEDs lit
	assign vout_mode = mode_r[2] || (!cfg1_r[`FFC_C1_TX2_MODE] && second_transmit_pin);

	// Registered drive outputs; overtemp forces off boost, LEDs, indicator and voltage mode
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			led_flash_on <= 1'b0;
			led_torch_on <= 1'b0;
			led_flash_level <= 4'h0;
			led_torch_level <= 3'h0;
			indicator_on <= 1'b0;
			indicator_level <= 2'h0;
			boost_enable <= 1'b0;
			supply_monitor_enable <= 1'b0;
			uv_threshold_sel <= 2'h0;
			output_level_select <= 1'b0;
			voltage_mode_active <= 1'b0;
			light_load_enable <= 1'b0;
		end else begin
			led_flash_on <= !hw_off && !overtemp_in && in_flash && !torch_force && !off_force;
			led_torch_on <= !hw_off && !overtemp_in && !off_force && ((in_flash && torch_force) ||
				(sw_torch && !in_flash));
			led_flash_level <= level_r;
			led_torch_level <= torch_r[5:3];
			indicator_on <= !hw_off && !overtemp_in && (mode_r[1:0] == 2'b01) &&
				!cfg1_r[`FFC_C1_THERM_MODE];
			indicator_level <= torch_r[7:6];
			boost_enable <= !hw_off && !overtemp_in && (in_flash || sw_torch || vout_mode);
			supply_monitor_enable <= supmon_r[`FFC_SM_EN];
			uv_threshold_sel <= supmon_r[2:1];
			output_level_select <= cfg1_r[`FFC_C1_OUT_LVL];
			voltage_mode_active <= !hw_off && !overtemp_in && vout_mode;
			light_load_enable <= !hw_off && vout_mode && !cfg1_r[`FFC_C1_LL_DIS] && !in_flash &&
				!sw_torch && (mode_r[1:0] != 2'b01);
		end
	end

	// Checks
	sequence s_flash_begin;
		(st_r == FFC_IDLE) && flash_req && !overtemp_in && !hw_off;
	endsequence
	sequence s_ramp_entered;
		(st_r == FFC_RAMP) && (level_r == 4'h0);
	endsequence

	property p_flash_start;
		@(posedge mclk) disable iff (!reset_n)
		s_flash_begin |=> s_ramp_entered ##0 !status_r[`FFC_ST_EXPIRY];
	endproperty
	a_flash_start: assert property (p_flash_start) else $error("flash start missed");

	property p_ramp_step;
		@(posedge mclk) disable iff (!reset_n || hw_off)
		(in_flash && ramp_tick && level_r != flash_r[6:3] && flash_req && !to_expire && !overtemp_in)
			|=> level_r == $past(level_r) + 4'h1;
	endproperty
	a_ramp_step: assert property (p_ramp_step) else $error("ramp step wrong");

	property p_overtemp_off;
		@(posedge mclk) disable iff (!reset_n)
		overtemp_in |=> !boost_enable && !led_flash_on && !led_torch_on && !indicator_on;
	endproperty
	a_overtemp_off: assert property (p_overtemp_off) else $error("overtemp left drive on");

	property p_expiry_flag;
		@(posedge mclk) disable iff (!reset_n || hw_off)
		to_expire |=> status_r[`FFC_ST_EXPIRY] && (st_r == FFC_DONE || st_r == FFC_IDLE);
	endproperty
	a_expiry_flag: assert property (p_expiry_flag) else $error("expiry flag missing");

	property p_status_read;
		@(posedge mclk) disable iff (!reset_n || hw_off)
		status_rd |=> (reg_rdata == $past(status_r)) && (status_r == $past(set_v));
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read not atomic");

	property p_supply_flag;
		@(posedge mclk) disable iff (!reset_n || hw_off)
		(supmon_r[`FFC_SM_EN] && supply_undervoltage) |=> status_r[`FFC_ST_SUPPLY] && uv_hold_r;
	endproperty
	a_supply_flag: assert property (p_supply_flag) else $error("undervoltage not latched");

	property p_led_fail;
		@(posedge mclk) disable iff (!reset_n || hw_off)
		(short_ok || open_ok) |=> status_r[`FFC_ST_LED_FAIL];
	endproperty
	a_led_fail: assert property (p_led_fail) else $error("LED failure not flagged");

	property p_tx1_flag;
		@(posedge mclk) disable iff (!reset_n || hw_off)
		(!cfg1_r[`FFC_C1_TX1_TORCH] && $rose(first_transmit_pin)) |=> status_r[`FFC_ST_TX1];
	endproperty
	a_tx1_flag: assert property (p_tx1_flag) else $error("transmit one flag missing");

	property p_light_load;
		@(posedge mclk) disable iff (!reset_n)
		light_load_enable |-> !led_flash_on && !led_torch_on && $past(vout_mode);
	endproperty
	a_light_load: assert property (p_light_load) else $error("light load with LEDs on");
endmodule

// ===== dv/ffc_host.sv
`timescale 1ns/1ns
// Host side: register port master and flash strobe pin
module ffc_host (
	input wire logic mclk,
	input wire ffc_pkg::ffc_byte_t reg_rdata,
	output logic [7:0] reg_addr,
	output ffc_pkg::ffc_byte_t reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic strobe_pin
);
	import ffc_pkg::*;
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		strobe_pin = 1'b0;
	end
	// Mode value 11 starts a flash, 00 ends it early
	task automatic wr(input logic [7:0] a, input ffc_byte_t v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_wdata <= ~v; // Scrambled so a late sample shows
	endtask
	// Data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output ffc_byte_t v);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// High requests a flash, low ends it in level mode
	task automatic strobe(input logic v);
		@(posedge mclk);
		strobe_pin <= v;
	endtask
endmodule

// ===== dv/test_ffc_top.sv
`timescale 1ns/1ns
`define CK(nm, e, a) begin num_checks++; if ((e) !== (a)) begin err_total++; \
$display("[ERR] %s exp %0h got %0h", nm, e, a); end end
module test_ffc_top;
	import ffc_pkg::*;
	localparam int SQ = 20;
	localparam int TS = 500;
	logic mclk, reset_n, hardware_enable_pin, reg_wr, reg_rd, strobe_pin;
	logic first_transmit_pin, second_transmit_pin, overtemp_in, output_overvoltage;
	logic led_short_in, thermistor_trip, supply_undervoltage, supply_recovered;
	logic boost_enable, led_flash_on, led_torch_on, supply_monitor_enable, indicator_on;
	logic [2:0] led_torch_level;
	logic output_level_select, voltage_mode_active, light_load_enable;
	logic [7:0] reg_addr;
	logic [3:0] led_flash_level, lvl;
	logic [1:0] uv_threshold_sel, indicator_level;
	ffc_byte_t reg_wdata, reg_rdata, exp_st, d;
	logic [31:0] seed, r;
	int err_total, num_checks, cnt, n, el;
	time t0;
	logic [7:0] ra [7] = '{8'h80, 8'ha0, 8'hb0, 8'hc0, 8'he0, 8'hf0, 8'h10};
	logic [7:0] rv [7] = '{8'hf0, 8'h50, 8'h68, 8'h4f, 8'h42, 8'hf0, 8'h00};

	ffc_top #(.SHORT_QUAL_CYC(SQ), .TIMEOUT_STEP_CYC(TS)) i_ffc_top (
		.mclk, .reset_n, .hardware_enable_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .strobe_pin, .first_transmit_pin, .second_transmit_pin, .overtemp_in,
		.output_overvoltage, .led_short_in, .thermistor_trip, .supply_undervoltage,
		.supply_recovered, .boost_enable, .led_flash_on, .led_torch_on, .led_flash_level,
		.led_torch_level, .indicator_on, .indicator_level, .supply_monitor_enable,
		.uv_threshold_sel, .output_level_select, .voltage_mode_active, .light_load_enable
	);
	ffc_host u_host (.mclk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .strobe_pin);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task automatic rchk(input logic [7:0] a, input ffc_byte_t e);
		u_host.rd(a, d);
		`CK("rdata", e, d)
	endtask
	// Status model: events accumulate, a read compares and clears all
	task automatic st();
		rchk(8'hd0, exp_st);
		exp_st = 8'h00;
	endtask
	// Bounded wait, so a stuck flash shows up as a mismatch
	task automatic wait_fl(input logic v);
		cnt = 0;
		while (led_flash_on !== v && cnt < 9000) begin
			cyc(1);
			cnt++;
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// Longest path is one full flash timeout, about 8000 cycles
	initial begin
		repeat (40000) @(posedge mclk);
		err_total++;
		tally_and_finish();
	end
	initial begin
		{reset_n, first_transmit_pin, second_transmit_pin, overtemp_in} = 4'h0;
		{output_overvoltage, led_short_in, thermistor_trip} = 3'h0;
		{supply_undervoltage, supply_recovered} = 2'h0;
		hardware_enable_pin = 1'b1;
		seed = 32'h96a9f656;
		exp_st = 8'h40;
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		cyc(1);
		st();
		u_host.wr(8'hd0, 8'hff);
		st();
		foreach (ra[i]) rchk(ra[i], rv[i]);
		$display("reset test done");
		// Config bits drive their outputs directly
		repeat (4) begin
			r = rnd();
			u_host.wr(8'h80, {5'h00, r[2:0]});
			u_host.wr(8'he0, {6'h10, r[4:3]});
			u_host.wr(8'ha0, {5'h0a, r[5], 2'b00});
			@(posedge mclk) second_transmit_pin <= r[6];
			cyc(3);
			`CK("mon_en", r[0], supply_monitor_enable)
			`CK("uv_sel", r[2:1], uv_threshold_sel)
			`CK("out_lvl", r[4], output_level_select)
			`CK("vmode", r[5] | r[6], voltage_mode_active)
			`CK("ll_en", (r[5] | r[6]) & ~r[3], light_load_enable)
		end
		@(posedge mclk) second_transmit_pin <= 1'b0;
		u_host.wr(8'h80, 8'h00);
		u_host.wr(8'ha0, 8'h50);
		$display("config test done");
		// Register flash ramps from zero, then runs into the timeout
		lvl = 4'(rnd() % 3 + 2);
		u_host.wr(8'hb0, {1'b0, lvl, 3'b011});
		wait_fl(1'b1);
		t0 = $time;
		`CK("flash_on", 1'b1, led_flash_on)
		`CK("level", 4'h0, led_flash_level)
		cyc(lvl * 400 - 8);
		`CK("level", lvl - 4'h1, led_flash_level)
		cyc(16);
		`CK("level", lvl, led_flash_level)
		wait_fl(1'b0);
		el = int'(($time - t0) / 40);
		`CK("t_out", 1'b1, el > 16 * TS - 10 && el < 16 * TS + 10)
		exp_st[0] = 1'b1;
		rchk(8'hb0, {1'b0, lvl, 3'b000});
		// Next flash by strobe clears the pending expiry flag
		exp_st[0] = 1'b0;
		u_host.strobe(1'b1);
		wait_fl(1'b1);
		`CK("flash_on", 1'b1, led_flash_on)
		st();
		repeat (2) begin
			@(posedge mclk) overtemp_in <= 1'b1;
			cyc(4);
			`CK("ot_off", 1'b0, boost_enable | led_flash_on)
			@(posedge mclk) overtemp_in <= 1'b0;
			wait_fl(1'b1);
			`CK("ot_restart", 1'b1, led_flash_on)
		end
		exp_st[1] = 1'b1;
		st();
		st();
		// Open and short, each once below and once above its persistence
		for (int k = 0; k < 4; k++) begin
			n = k[1] ? (k[0] ? SQ + 8 : SQ - 8) : (k[0] ? 58 : 42);
			@(posedge mclk) {led_short_in, output_overvoltage} <= k[1] ? 2'b10 : 2'b01;
			cyc(n);
			@(posedge mclk) {led_short_in, output_overvoltage} <= 2'b00;
			cyc(3);
			exp_st[2] = k[0];
			st();
		end
		@(posedge mclk) led_short_in <= 1'b1;
		cyc(SQ + 8);
		@(posedge mclk);
		led_short_in <= 1'b0;
		hardware_enable_pin <= 1'b0;
		cyc(2);
		@(posedge mclk) hardware_enable_pin <= 1'b1;
		exp_st = 8'h40;
		st();
		u_host.strobe(1'b0);
		wait_fl(1'b0);
		`CK("early_end", 1'b0, led_flash_on)
		st();
		$display("flash test done");
		// Undervoltage: torch then off, held until read and recovery
		for (int k = 0; k < 2; k++) begin
			u_host.wr(8'hf0, k[0] ? 8'hf8 : 8'hf0);
			u_host.wr(8'h80, 8'h01);
			u_host.wr(8'hb0, {1'b0, lvl, 3'b011});
			wait_fl(1'b1);
			@(posedge mclk) supply_undervoltage <= 1'b1;
			cyc(4);
			@(posedge mclk) supply_undervoltage <= 1'b0;
			cyc(4);
			`CK("uv_force", {!k[0], 1'b0}, {led_torch_on, led_flash_on})
			exp_st[6] = 1'b1;
			st();
			cyc(8);
			`CK("uv_hold", 1'b0, led_flash_on)
			@(posedge mclk) supply_recovered <= 1'b1;
			@(posedge mclk) supply_recovered <= 1'b0;
			wait_fl(1'b1);
			`CK("uv_resume", 1'b1, led_flash_on)
			u_host.wr(8'hb0, {1'b0, lvl, 3'b000});
			wait_fl(1'b0);
			`CK("mode_end", 1'b0, led_flash_on)
		end
		st();
		$display("supply test done");
		// Edge strobe: a short pulse is latched, the pin falling does not end it
		u_host.wr(8'he0, 8'h46);
		u_host.strobe(1'b1);
		u_host.strobe(1'b0);
		wait_fl(1'b1);
		cyc(8);
		`CK("edge_hold", 1'b1, led_flash_on)
		@(posedge mclk) hardware_enable_pin <= 1'b0;
		@(posedge mclk) hardware_enable_pin <= 1'b1;
		wait_fl(1'b0);
		exp_st = 8'h40;
		st();
		// Transmit events: first pin on rise, second per polarity bit
		@(posedge mclk) first_transmit_pin <= 1'b1;
		cyc(3);
		@(posedge mclk) first_transmit_pin <= 1'b0;
		cyc(3);
		exp_st[3] = 1'b1;
		st();
		for (int k = 0; k < 2; k++) begin
			u_host.wr(8'he0, k[0] ? 8'h22 : 8'h62);
			@(posedge mclk) second_transmit_pin <= 1'b1;
			cyc(3);
			exp_st[4] = !k[0];
			st();
			@(posedge mclk) second_transmit_pin <= 1'b0;
			cyc(3);
			exp_st[4] = k[0];
			st();
		end
		// Thermistor trip while torch is on
		u_host.wr(8'he0, 8'h4a);
		u_host.wr(8'ha0, 8'h52);
		cyc(4);
		@(posedge mclk) thermistor_trip <= 1'b1;
		cyc(3);
		@(posedge mclk) thermistor_trip <= 1'b0;
		cyc(3);
		`CK("torch", 4'ha, {led_torch_on, led_torch_level})
		exp_st[5] = 1'b1;
		st();
		// Indicator source also goes dark on overtemp
		u_host.wr(8'he0, 8'h42);
		u_host.wr(8'ha0, 8'hc9);
		cyc(3);
		`CK("ind_on", 3'h7, {indicator_on, indicator_level})
		@(posedge mclk) overtemp_in <= 1'b1;
		cyc(3);
		`CK("ind_ot", 1'b0, indicator_on)
		@(posedge mclk) overtemp_in <= 1'b0;
		exp_st[1] = 1'b1;
		st();
		$display("event test done");
		tally_and_finish();
	end
endmodule
